// file: logic/acw_core.sv
// Command engine for standby, translate, wear level and the write commands
`timescale 1ns/1ps
module acw_core #(
	parameter int SEC_WORDS = acw_pkg::SEC_BYTES / 2,
	parameter int MAX_BLOCK = acw_pkg::BLOCK_DEF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [3:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	output logic intrq,
	output logic dmarq,
	input wire logic dmack_n,
	input wire logic iowr_n,
	input wire logic [15:0] dma_data,
	output acw_pkg::acw_media_s media,
	input wire acw_pkg::acw_minfo_s minfo,
	output logic asleep
);
	localparam int IW = $clog2(SEC_WORDS);
	localparam int BSY_CYC = acw_pkg::BSY_MAX_CYC;

	// Refuse sizes the translate map or the counters cannot serve
	if (SEC_WORDS < 16 || (1 << IW) != SEC_WORDS || MAX_BLOCK < 1 || MAX_BLOCK > 255) begin : g_chk
		$error("acw_core: unsupported parameters");
	end

	typedef struct packed {
		acw_pkg::acw_state_e st;
		acw_pkg::acw_tf_s tf;
		logic [7:0] cmd;
		logic bsy;
		logic drq;
		logic err;
		logic abrt;
		logic irq;
		logic sleep;
		logic b8;
		logic men;
		logic failed;
		logic hold;
		logic dmarq;
		logic [7:0] bsz;
		logic [8:0] rem;
		logic [8:0] bleft;
		logic [IW-1:0] widx;
		logic [2:0] ack_p;
		logic [2:0] wr_p;
		logic ack_f;
		logic wr_f;
		logic [15:0] d1;
		logic [15:0] d2;
		logic [15:0] d3;
		logic [15:0] rdata;
		acw_pkg::acw_media_s m;
		logic [SEC_WORDS-1:0][15:0] sbuf;
	} acw_reg_s;

	acw_reg_s r_reg;
	acw_reg_s r_next;
	logic cmd_acc;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// One byte of the translate information buffer
	function automatic logic [7:0] xbyte(input logic [15:0] i, input acw_pkg::acw_tf_s tf,
		input acw_pkg::acw_minfo_s mi);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			acw_pkg::X_CYL_HI: b = tf.chi;
			acw_pkg::X_CYL_LO: b = tf.clo;
			acw_pkg::X_HEAD: b = {4'h0, tf.drv[3:0]};
			acw_pkg::X_SECT: b = tf.sec;
			acw_pkg::X_LBA2: b = tf.chi;
			acw_pkg::X_LBA1: b = tf.clo;
			acw_pkg::X_LBA0: b = tf.sec;
			acw_pkg::X_ERASED: b = mi.erased ? acw_pkg::ERASED_BYTE : 8'h00;
			acw_pkg::X_HOT2: b = mi.hot_ok ? mi.hot[23:16] : 8'h00;
			acw_pkg::X_HOT1: b = mi.hot_ok ? mi.hot[15:8] : 8'h00;
			acw_pkg::X_HOT0: b = mi.hot_ok ? mi.hot[7:0] : 8'h00;
			default: b = 8'h00; // Reserved bytes read zero
		endcase
		return b;
	endfunction

	// Sectors in the next block: full block or remainder
	function automatic logic [8:0] blk(input logic [7:0] bsz, input logic [8:0] rem);
		return ({1'b0, bsz} < rem) ? {1'b0, bsz} : rem;
	endfunction

	// Commands are only taken when idle; host waits on busy
	assign cmd_acc = bus_wr && bus_addr == acw_pkg::A_CMD && r_reg.st == acw_pkg::S_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic strobe;
		logic word_in;
		logic [15:0] wv;
		logic fin;
		logic abt;
		logic [8:0] cnt9;
		strobe = 1'b0;
		word_in = 1'b0;
		wv = 16'h0000;
		fin = 1'b0;
		abt = 1'b0;
		cnt9 = (r_reg.tf.cnt == 8'h00) ? acw_pkg::CNT_ZERO_AS : {1'b0, r_reg.tf.cnt};
		r_next = r_reg;
		r_next.m.wvalid = 1'b0;
		r_next.m.commit = 1'b0;
		r_next.rdata = 16'h0000;

		// Pin synchronisers; a level counts when stages two and three agree
		r_next.ack_p = {r_reg.ack_p[1:0], dmack_n};
		r_next.wr_p = {r_reg.wr_p[1:0], iowr_n};
		r_next.d1 = dma_data;
		r_next.d2 = r_reg.d1;
		r_next.d3 = r_reg.d2;
		if (r_reg.ack_p[1] == r_reg.ack_p[2]) begin
			r_next.ack_f = r_reg.ack_p[2];
		end
		if (r_reg.wr_p[1] == r_reg.wr_p[2]) begin
			r_next.wr_f = r_reg.wr_p[2];
		end
		// Falling edge of the filtered write strobe while acknowledged
		strobe = r_reg.wr_f && !r_reg.wr_p[2] && !r_reg.wr_p[1] && !r_reg.ack_f;

		// Register reads, answered one cycle later
		if (bus_rd) begin
			case (bus_addr)
				acw_pkg::A_DATA: begin
					if (r_reg.st == acw_pkg::S_IN) begin
						r_next.rdata = {xbyte(16'({r_reg.widx, 1'b1}), r_reg.tf, minfo),
							xbyte(16'({r_reg.widx, 1'b0}), r_reg.tf, minfo)};
						r_next.widx = r_reg.widx + 1'b1;
						if (r_reg.widx == IW'(SEC_WORDS - 1)) begin
							r_next.drq = 1'b0;
							r_next.st = acw_pkg::S_IDLE;
						end
					end
				end
				acw_pkg::A_ERR: r_next.rdata[acw_pkg::ER_ABRT] = r_reg.abrt;
				acw_pkg::A_CNT: r_next.rdata[7:0] = r_reg.tf.cnt;
				acw_pkg::A_SEC: r_next.rdata[7:0] = r_reg.tf.sec;
				acw_pkg::A_CLO: r_next.rdata[7:0] = r_reg.tf.clo;
				acw_pkg::A_CHI: r_next.rdata[7:0] = r_reg.tf.chi;
				acw_pkg::A_DRV: r_next.rdata[7:0] = r_reg.tf.drv;
				acw_pkg::A_CMD: begin
					r_next.rdata[acw_pkg::ST_BSY] = r_reg.bsy;
					r_next.rdata[acw_pkg::ST_RDY] = !r_reg.bsy;
					r_next.rdata[acw_pkg::ST_DRQ] = r_reg.drq;
					r_next.rdata[acw_pkg::ST_ERR] = r_reg.err;
					r_next.irq = 1'b0; // Status read acknowledges; later sets win
				end
				acw_pkg::A_CFG: begin
					r_next.rdata[7:0] = r_reg.bsz;
					r_next.rdata[acw_pkg::CFG_MEN] = r_reg.men;
					r_next.rdata[acw_pkg::CFG_B8] = r_reg.b8;
				end
				default: r_next.rdata = 16'h0000;
			endcase
		end

		// Register writes; task file is frozen while a command runs
		if (bus_wr) begin
			if (r_reg.st == acw_pkg::S_IDLE) begin
				case (bus_addr)
					acw_pkg::A_ERR: r_next.tf.feat = bus_wdata[7:0];
					acw_pkg::A_CNT: r_next.tf.cnt = bus_wdata[7:0];
					acw_pkg::A_SEC: r_next.tf.sec = bus_wdata[7:0];
					acw_pkg::A_CLO: r_next.tf.clo = bus_wdata[7:0];
					acw_pkg::A_CHI: r_next.tf.chi = bus_wdata[7:0];
					acw_pkg::A_DRV: r_next.tf.drv = bus_wdata[7:0];
					default: r_next.tf = r_reg.tf;
				endcase
			end
			if (bus_addr == acw_pkg::A_DATA && r_reg.st == acw_pkg::S_OUT && r_reg.drq) begin
				word_in = 1'b1;
				wv = bus_wdata;
			end
		end
		if (r_reg.st == acw_pkg::S_DMA && r_reg.dmarq && strobe) begin
			word_in = 1'b1;
			wv = r_reg.d3;
		end

		// Command taken: busy next edge, wakes from sleep
		if (cmd_acc) begin
			r_next.cmd = bus_wdata[7:0];
			r_next.st = acw_pkg::S_EXEC;
			r_next.bsy = 1'b1;
			r_next.sleep = 1'b0;
			r_next.irq = 1'b0;
			r_next.err = 1'b0;
			r_next.abrt = 1'b0;
			r_next.failed = 1'b0;
			r_next.hold = 1'b0;
			r_next.widx = '0;
		end

		// Word intake into the sector buffer and out to the media
		if (word_in) begin
			r_next.sbuf[r_reg.widx] = wv;
			r_next.widx = r_reg.widx + 1'b1;
			r_next.m.wvalid = !r_reg.failed && r_reg.cmd != acw_pkg::C_WBUF;
			r_next.m.wdata = wv;
			if (r_reg.widx == IW'(SEC_WORDS - 1)) begin
				// Sector complete: stall the host until the media answers
				r_next.hold = 1'b1;
				r_next.bleft = r_reg.bleft - 9'h001;
				r_next.m.commit = !r_reg.failed && r_reg.cmd != acw_pkg::C_WBUF;
				r_next.m.lba = {r_reg.tf.drv[3:0], r_reg.tf.chi, r_reg.tf.clo, r_reg.tf.sec};
				r_next.drq = 1'b0;
				r_next.dmarq = 1'b0;
				r_next.bsy = 1'b1;
			end
		end

		// Media answer: failing sector freezes address and count
		if (r_reg.m.commit) begin
			if (minfo.fail) begin
				r_next.failed = 1'b1;
			end else begin
				r_next.rem = r_reg.rem - 9'h001;
				r_next.tf.cnt = 8'(r_reg.rem - 9'h001);
				if (r_reg.rem != 9'h001) begin
					{r_next.tf.drv[3:0], r_next.tf.chi, r_next.tf.clo, r_next.tf.sec} =
						28'({r_reg.tf.drv[3:0], r_reg.tf.chi, r_reg.tf.clo, r_reg.tf.sec} + 28'h0000001);
				end
			end
		end

		// Sector settled: finish, next block or next sector
		if (r_reg.hold && !r_reg.m.commit) begin
			r_next.hold = 1'b0;
			if (r_reg.cmd == acw_pkg::C_WBUF || r_reg.rem == 9'h000) begin
				fin = 1'b1;
			end else if (r_reg.failed && (r_reg.st == acw_pkg::S_DMA || r_reg.bleft == 9'h000)) begin
				fin = 1'b1;
			end else if (r_reg.st == acw_pkg::S_DMA) begin
				r_next.dmarq = 1'b1;
			end else if (r_reg.bleft == 9'h000) begin
				r_next.bleft = blk(r_reg.bsz, r_reg.rem);
				r_next.drq = 1'b1;
				r_next.bsy = 1'b0;
				r_next.irq = 1'b1;
			end else begin
				r_next.drq = 1'b1;
				r_next.bsy = 1'b0;
			end
		end

		// Command dispatch, one cycle after it is taken
		if (r_reg.st == acw_pkg::S_EXEC) begin
			case (r_reg.cmd)
				acw_pkg::C_STBYI, acw_pkg::C_STBYI2: begin
					r_next.sleep = 1'b1;
					fin = 1'b1;
				end
				acw_pkg::C_WEAR: begin
					r_next.tf.cnt = 8'h00;
					fin = 1'b1;
				end
				acw_pkg::C_XLAT: begin
					r_next.st = acw_pkg::S_IN;
					r_next.drq = 1'b1;
					r_next.bsy = 1'b0;
					r_next.irq = 1'b1;
				end
				acw_pkg::C_WBUF: begin
					r_next.st = acw_pkg::S_OUT;
					r_next.bleft = 9'h001;
					r_next.drq = 1'b1;
					r_next.bsy = 1'b0;
				end
				acw_pkg::C_WMUL: begin
					if (!r_reg.men) begin
						abt = 1'b1;
					end else begin
						r_next.st = acw_pkg::S_OUT;
						r_next.rem = cnt9;
						r_next.bleft = blk(r_reg.bsz, cnt9);
						r_next.drq = 1'b1;
						r_next.bsy = 1'b0;
					end
				end
				acw_pkg::C_WDMA: begin
					if (r_reg.b8) begin
						abt = 1'b1;
					end else begin
						r_next.st = acw_pkg::S_DMA;
						r_next.rem = cnt9;
						r_next.dmarq = 1'b1;
					end
				end
				acw_pkg::C_SMUL: begin
					if (r_reg.tf.cnt == 8'h00) begin
						r_next.men = 1'b0;
						fin = 1'b1;
					end else if (r_reg.tf.cnt <= 8'(MAX_BLOCK)) begin
						r_next.men = 1'b1;
						r_next.bsz = r_reg.tf.cnt;
						fin = 1'b1;
					end else begin
						r_next.men = 1'b0;
						abt = 1'b1;
					end
				end
				acw_pkg::C_SETF: begin
					if (r_reg.tf.feat == acw_pkg::F_B8_ON) begin
						r_next.b8 = 1'b1;
					end else if (r_reg.tf.feat == acw_pkg::F_B8_OFF) begin
						r_next.b8 = 1'b0;
					end
					fin = 1'b1;
				end
				default: abt = 1'b1;
			endcase
		end

		// Completion: drop busy and request, raise the interrupt
		if (fin || abt) begin
			r_next.st = acw_pkg::S_IDLE;
			r_next.bsy = 1'b0;
			r_next.drq = 1'b0;
			r_next.dmarq = 1'b0;
			r_next.irq = 1'b1;
			r_next.err = abt || r_reg.failed;
			r_next.abrt = abt;
		end
	end

	// State register; reset wins, clock enable freezes everything else
	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from flops
	assign bus_rdata = r_reg.rdata;
	assign intrq = r_reg.irq;
	assign dmarq = r_reg.dmarq;
	assign media = r_reg.m;
	assign asleep = r_reg.sleep;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst || !ce);

	sequence s_cmd(logic [7:0] c);
		cmd_acc && bus_wdata[7:0] == c;
	endsequence
	sequence s_done;
		r_reg.st == acw_pkg::S_IDLE && r_reg.irq && !r_reg.bsy;
	endsequence

	property p_stby;
		s_cmd(acw_pkg::C_STBYI) or s_cmd(acw_pkg::C_STBYI2) |-> ##2 (s_done and r_reg.sleep);
	endproperty
	a_stby: assert property (p_stby) else $error("standby did not sleep with interrupt");

	property p_wake;
		r_reg.sleep && cmd_acc |=> !r_reg.sleep;
	endproperty
	a_wake: assert property (p_wake) else $error("command did not wake");

	property p_xlat;
		s_cmd(acw_pkg::C_XLAT) |-> ##2 (r_reg.drq && r_reg.irq && r_reg.st == acw_pkg::S_IN);
	endproperty
	a_xlat: assert property (p_xlat) else $error("translate data not offered");

	property p_wear;
		s_cmd(acw_pkg::C_WEAR) |-> ##2 (s_done and r_reg.tf.cnt == 8'h00);
	endproperty
	a_wear: assert property (p_wear) else $error("wear level count not zero");

	property p_dmacnt;
		s_cmd(acw_pkg::C_WDMA) ##0 (!r_reg.b8 && r_reg.tf.cnt == 8'h00)
			|-> ##2 (r_reg.rem == acw_pkg::CNT_ZERO_AS && r_reg.bsy && r_reg.dmarq);
	endproperty
	a_dmacnt: assert property (p_dmacnt) else $error("zero count not 256");

	property p_dmairq;
		r_reg.st == acw_pkg::S_DMA |-> !intrq && r_reg.bsy;
	endproperty
	a_dmairq: assert property (p_dmairq) else $error("interrupt or idle during dma");

	property p_dma8;
		s_cmd(acw_pkg::C_WDMA) ##0 r_reg.b8 |-> ##2 (r_reg.abrt && r_reg.err && !dmarq);
	endproperty
	a_dma8: assert property (p_dma8) else $error("dma not aborted in 8-bit mode");

	property p_bsy;
		s_cmd(acw_pkg::C_WMUL) |-> ##[1:BSY_CYC] r_reg.bsy;
	endproperty
	a_bsy: assert property (p_bsy) else $error("busy late after block write");

	property p_mulabt;
		s_cmd(acw_pkg::C_WMUL) ##0 !r_reg.men |-> ##2 (s_done ##0 r_reg.abrt);
	endproperty
	a_mulabt: assert property (p_mulabt) else $error("block write not aborted");

	property p_fail;
		r_reg.m.commit && minfo.fail && !r_reg.failed |=> r_reg.failed && $stable(r_reg.rem);
	endproperty
	a_fail: assert property (p_fail) else $error("failing sector not held");

	property p_smul;
		s_cmd(acw_pkg::C_SMUL) ##0 (r_reg.tf.cnt > 8'(MAX_BLOCK)) |-> ##2 (r_reg.abrt && !r_reg.men);
	endproperty
	a_smul: assert property (p_smul) else $error("bad block size accepted");
endmodule

// file: shared/acw_pkg.sv
// Constants and types of the ATA write and power command block
// What this block does
// - Standby immediate: busy, sleep, interrupt at once
// - Any new command wakes from sleep
// - Translate returns 512 byte sector information
// - Bytes 0-6: cylinder, head, sector, LBA
// - Byte 13h is FFh erased, 00h not
// - Bytes 18h-1Ah hot count, else zero
// - Wear level is no-op, count reads zero
// - Write buffer takes 512 bytes into buffer
// - DMA write moves 1 to 256 sectors
// - DMA write holds busy while moving data
// - Request asserted; one word per host strobe
// - DMA interrupts only at end or error
// - DMA write aborts when 8-bit mode enabled
// - Busy within 400 ns of block write
// - Interrupt per block, not sector; DRQ drops after each sector
// - Full blocks then remainder partial block
// - Block write aborts when block mode off
// - Error posted after block; stop there
// - Error leaves failing address and residual count
// - Block sizes one to MAX_BLOCK are supported, one by default
// - Bad block size aborts, disables block mode
// - Feature 01h enables 8-bit mode
package acw_pkg;
	// Register indices on the task-file port
	localparam logic [3:0] A_DATA = 4'h0;
	localparam logic [3:0] A_ERR = 4'h1;
	localparam logic [3:0] A_CNT = 4'h2;
	localparam logic [3:0] A_SEC = 4'h3;
	localparam logic [3:0] A_CLO = 4'h4;
	localparam logic [3:0] A_CHI = 4'h5;
	localparam logic [3:0] A_DRV = 4'h6;
	localparam logic [3:0] A_CMD = 4'h7;
	localparam logic [3:0] A_CFG = 4'h8;
	// Command codes
	localparam logic [7:0] C_STBYI = 8'h94;
	localparam logic [7:0] C_STBYI2 = 8'hE0;
	localparam logic [7:0] C_XLAT = 8'h87;
	localparam logic [7:0] C_WEAR = 8'hF5;
	localparam logic [7:0] C_WBUF = 8'hE8;
	localparam logic [7:0] C_WDMA = 8'hCA;
	localparam logic [7:0] C_WMUL = 8'hC5;
	localparam logic [7:0] C_SMUL = 8'hC6;
	localparam logic [7:0] C_SETF = 8'hEF;
	localparam logic [7:0] F_B8_ON = 8'h01;
	localparam logic [7:0] F_B8_OFF = 8'h81;
	// Status, error and config bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_ABRT = 2;
	localparam int CFG_MEN = 8;
	localparam int CFG_B8 = 9;
	// Translate buffer byte offsets
	localparam logic [15:0] X_CYL_HI = 16'h0000;
	localparam logic [15:0] X_CYL_LO = 16'h0001;
	localparam logic [15:0] X_HEAD = 16'h0002;
	localparam logic [15:0] X_SECT = 16'h0003;
	localparam logic [15:0] X_LBA2 = 16'h0004;
	localparam logic [15:0] X_LBA1 = 16'h0005;
	localparam logic [15:0] X_LBA0 = 16'h0006;
	localparam logic [15:0] X_ERASED = 16'h0013;
	localparam logic [15:0] X_HOT2 = 16'h0018;
	localparam logic [15:0] X_HOT1 = 16'h0019;
	localparam logic [15:0] X_HOT0 = 16'h001A;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [8:0] CNT_ZERO_AS = 9'h100;
	localparam int SEC_BYTES = 512;
	localparam int BLOCK_DEF = 1;
	// Timing
	localparam int CLK_MHZ = 20;
	localparam int BSY_MAX_NS = 400;
	localparam int BSY_MAX_CYC = BSY_MAX_NS * CLK_MHZ / 1000;
	typedef enum logic [2:0] {S_IDLE, S_EXEC, S_IN, S_OUT, S_DMA} acw_state_e;
	typedef struct packed {
		logic [7:0] feat;
		logic [7:0] cnt;
		logic [7:0] sec;
		logic [7:0] clo;
		logic [7:0] chi;
		logic [7:0] drv;
	} acw_tf_s;
	typedef struct packed {
		logic wvalid;
		logic [15:0] wdata;
		logic commit;
		logic [27:0] lba;
	} acw_media_s;
	typedef struct packed {
		logic fail;
		logic erased;
		logic hot_ok;
		logic [23:0] hot;
	} acw_minfo_s;
endpackage

// file: tb/acw_dma_host.sv
// Host-side DMA model: acknowledge and one write strobe per word while the request stands
`timescale 1ns/1ps
module acw_dma_host (
	input wire logic clk,
	input wire logic dmarq,
	input wire logic slow,
	output logic dmack_n,
	output logic iowr_n,
	output logic [15:0] dma_data
);
	logic [15:0] word_reg;
	////////////////////////////////////////////////////////////////
	// Word source counts up so the bench can predict every word
	initial begin
		dmack_n = 1'b1;
		iowr_n = 1'b1;
		dma_data = 16'h0000;
		word_reg = 16'h0000;
		forever begin
			@(posedge clk);
			if (dmarq !== 1'b1) begin
				// Released lines toggle so stale data never looks valid
				dmack_n <= 1'b1;
				dma_data <= ~dma_data;
			end else begin
				dmack_n <= 1'b0;
				dma_data <= word_reg;
				@(posedge clk);
				iowr_n <= 1'b0;
				repeat (slow ? 7 : 4) @(posedge clk);
				iowr_n <= 1'b1;
				// Long high phase lets the request fall before another strobe
				repeat (slow ? 11 : 6) @(posedge clk);
				word_reg <= word_reg + 16'h0001;
			end
		end
	end
endmodule

// file: tb/acw_core_tb_top.sv
// Self-checking bench for the ATA write and power command engine
`timescale 1ns/1ps
module acw_core_tb_top;
	localparam int SW = 16;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] bus_addr = 4'h0;
	logic [15:0] bus_wdata = 16'h0000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [15:0] bus_rdata, dma_data, v;
	logic intrq, dmarq, dmack_n, iowr_n, asleep;
	logic slow = 1'b0;
	logic rs = 1'b0;
	acw_pkg::acw_media_s media;
	acw_pkg::acw_minfo_s minfo = 27'h0000000;
	logic [15:0] eq[$], mq[$], wq[$];
	logic [27:0] lq[$];
	logic [27:0] lba;
	logic [15:0] lf = 16'hC02C;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int wc = 0;
	int i;

	// Short sectors keep the 256-sector run affordable
	acw_core #(.SEC_WORDS(SW), .MAX_BLOCK(1)) dut_u (.clk(clk), .srst(srst), .ce(1'b1),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .intrq(intrq), .dmarq(dmarq), .dmack_n(dmack_n), .iowr_n(iowr_n),
		.dma_data(dma_data), .media(media), .minfo(minfo), .asleep(asleep));
	acw_dma_host host_u (.clk(clk), .dmarq(dmarq), .slow(slow), .dmack_n(dmack_n), .iowr_n(iowr_n),
		.dma_data(dma_data));

	always #25 clk = ~clk;

	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction

	task automatic chk(input logic [27:0] s, input logic [27:0] e, input logic [27:0] m);
		if (m !== 28'h0) begin
			cmp_count++;
			if ((s & m) !== (e & m)) begin
				n_mismatch++;
				$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	////////////////////////////////////////////////////////////////
	// Result watcher: read data in the cycle after the strobe, media words, commits
	always @(posedge clk) rs <= bus_rd;
	always @(negedge clk) begin
		if (rs) chk(28'(bus_rdata), 28'(eq.pop_front()), 28'(mq.pop_front()));
		if (media.wvalid) chk(28'(media.wdata), 28'(wq.size() ? wq.pop_front() : 16'hDEAD), 28'hFFFF);
		if (media.commit) chk(media.lba, lq.size() ? lq.pop_front() : 28'hFFFFFFF, 28'hFFFFFFF);
	end

	// Hang guard: the 256-sector transfer needs about 49000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m, output logic [15:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		eq.push_back(e);
		mq.push_back(m);
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		d = bus_rdata;
	endtask

	// Host polls busy and request before each sector of data
	task automatic wait_drq();
		int k;
		for (k = 0; k < 300; k++) begin
			rd(acw_pkg::A_CMD, 16'h0000, 16'h0000, v);
			if (v[3] === 1'b1) break;
		end
		chk(28'(v), 28'h8, 28'h88);
	endtask

	task automatic wait_irq();
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (intrq !== 1'b1 && k < 70000);
		chk(28'(intrq), 28'h1, 28'h1);
	endtask

	task automatic cmd_abort(input logic [7:0] c);
		wr(acw_pkg::A_CMD, {8'h00, c});
		wait_irq();
		rd(acw_pkg::A_CMD, 16'h0001, 16'h0089, v);
		rd(acw_pkg::A_ERR, 16'h0004, 16'h0004, v);
	endtask

	task automatic addr_set();
		v = rnd();
		lba = {v[11:0], rnd()};
		wr(acw_pkg::A_SEC, {8'h00, lba[7:0]});
		wr(acw_pkg::A_CLO, {8'h00, lba[15:8]});
		wr(acw_pkg::A_CHI, {8'h00, lba[23:16]});
		wr(acw_pkg::A_DRV, {8'h00, 4'hE, lba[27:24]});
	endtask

	task automatic xlat(input logic e, input logic k);
		logic [15:0] xe[SW];
		logic [15:0] xm[SW];
		logic [23:0] h;
		int j;
		addr_set();
		h = {rnd(), lf[7:0]};
		minfo.erased <= e;
		minfo.hot_ok <= k;
		minfo.hot <= h;
		for (j = 0; j < SW; j++) begin
			xe[j] = 16'h0000;
			xm[j] = 16'hFFFF;
		end
		xe[0] = {lba[15:8], lba[23:16]};
		xe[1] = {lba[7:0], 4'h0, lba[27:24]};
		xe[2] = xe[0];
		xe[3] = {8'h00, lba[7:0]};
		xe[9] = {e ? 8'hFF : 8'h00, 8'h00};
		xe[12] = k ? {h[15:8], h[23:16]} : 16'h0000;
		xe[13] = {8'h00, k ? h[7:0] : 8'h00};
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_XLAT});
		wait_irq();
		rd(acw_pkg::A_CMD, 16'h0008, 16'h0088, v);
		for (j = 0; j < SW; j++) rd(acw_pkg::A_DATA, xe[j], xm[j], v);
		rd(acw_pkg::A_CMD, 16'h0000, 16'h0088, v);
	endtask

	// Block write of n sectors; m are sent and the last of them fails when f is set
	task automatic wm(input logic [7:0] n, input int m, input logic f);
		int s;
		int j;
		addr_set();
		wr(acw_pkg::A_CNT, {8'h00, n});
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_WMUL});
		for (s = 0; s < m; s++) begin
			if (s > 0) wait_irq();
			wait_drq();
			minfo.fail <= f && s == m - 1;
			for (j = 0; j < SW; j++) begin
				v = rnd();
				wq.push_back(v);
				wr(acw_pkg::A_DATA, v);
			end
			lq.push_back(lba + 28'(s));
		end
		wait_irq();
		minfo.fail <= 1'b0;
		rd(acw_pkg::A_CMD, {15'h0000, f}, 16'h0089, v);
		if (f) begin
			lba = lba + 28'(m - 1);
			rd(acw_pkg::A_CNT, 16'(n - m + 1), 16'h00FF, v);
			rd(acw_pkg::A_SEC, {8'h00, lba[7:0]}, 16'h00FF, v);
		end
	endtask

	task automatic dma(input logic [7:0] n, input int ns, input logic sl);
		int j;
		slow <= sl;
		addr_set();
		for (j = 0; j < ns * SW; j++) wq.push_back(16'(wc + j));
		for (j = 0; j < ns; j++) lq.push_back(lba + 28'(j));
		wc += ns * SW;
		wr(acw_pkg::A_CNT, {8'h00, n});
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_WDMA});
		wait_irq();
		chk(28'(wq.size()), 28'h0, 28'hFFFFFFF);
		chk(28'(lq.size()), 28'h0, 28'hFFFFFFF);
		rd(acw_pkg::A_CMD, 16'h0000, 16'h0089, v);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence: power, translate, buffer, block writes, DMA
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(acw_pkg::A_CFG, 16'h0000, 16'h03FF, v);
		wr(4'hC, 16'hA5A5);
		rd(4'hC, 16'h0000, 16'hFFFF, v);
		done("reset");
		for (i = 0; i < 2; i++) begin
			wr(acw_pkg::A_CMD, {8'h00, i ? acw_pkg::C_STBYI2 : acw_pkg::C_STBYI});
			wait_irq();
			chk(28'(asleep), 28'h1, 28'h1);
			rd(acw_pkg::A_CMD, 16'h0000, 16'h0080, v);
		end
		wr(acw_pkg::A_CNT, rnd() | 16'h0001);
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_WEAR});
		wait_irq();
		chk(28'(asleep), 28'h0, 28'h1);
		rd(acw_pkg::A_CNT, 16'h0000, 16'h00FF, v);
		done("power");
		xlat(1'b1, 1'b1);
		xlat(1'b0, 1'b0);
		done("translate");
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_WBUF});
		wait_drq();
		for (i = 0; i < SW; i++) wr(acw_pkg::A_DATA, rnd());
		wait_irq();
		rd(acw_pkg::A_CMD, 16'h0000, 16'h0089, v);
		done("write buffer");
		cmd_abort(acw_pkg::C_WMUL);
		wr(acw_pkg::A_CNT, 16'h0002);
		cmd_abort(acw_pkg::C_SMUL);
		cmd_abort(acw_pkg::C_WMUL);
		// Zero block size disables block mode without an error
		wr(acw_pkg::A_CNT, 16'h0000);
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_SMUL});
		wait_irq();
		rd(acw_pkg::A_CMD, 16'h0000, 16'h0089, v);
		rd(acw_pkg::A_CFG, 16'h0000, 16'h0100, v);
		wr(acw_pkg::A_CNT, 16'h0001);
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_SMUL});
		wait_irq();
		rd(acw_pkg::A_CFG, 16'h0101, 16'h01FF, v);
		wm(8'h02, 2, 1'b0);
		wm(8'h03, 2, 1'b1);
		done("block write");
		wr(acw_pkg::A_ERR, {8'h00, acw_pkg::F_B8_ON});
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_SETF});
		wait_irq();
		rd(acw_pkg::A_CFG, 16'h0200, 16'h0200, v);
		cmd_abort(acw_pkg::C_WDMA);
		wr(acw_pkg::A_ERR, {8'h00, acw_pkg::F_B8_OFF});
		wr(acw_pkg::A_CMD, {8'h00, acw_pkg::C_SETF});
		wait_irq();
		dma(8'h02, 2, 1'b1);
		dma(8'h00, 256, 1'b0);
		done("dma");
		tally_and_finish();
	end
endmodule
